// ### pkg/ubrg_regs.svh
`ifndef UBRG_REGS_SVH
`define UBRG_REGS_SVH

// register byte addresses on the 16-byte window
`define UBRG_ADDR_TXCTL 4'h0
`define UBRG_ADDR_RXCTL 4'h4
`define UBRG_ADDR_DIV 4'h8
`define UBRG_ADDR_STAT 4'hC

// reset values, identical for every kind of reset
`define UBRG_TXCTL_RST 8'h02
`define UBRG_RXCTL_RST 8'h00
`define UBRG_DIV_RST 8'h00

// software-writable bits of the two control registers
`define UBRG_TXCTL_WMASK 8'hF5
`define UBRG_RXCTL_WMASK 8'hF8

// field positions in the transmit control register
`define UBRG_TX_CLKSRC_BIT 7
`define UBRG_TX_ENABLE_BIT 5
`define UBRG_TX_SYNC_BIT 4
`define UBRG_TX_HIGH_SPEED_BIT 2
`define UBRG_TX_SHIFT_EMPTY_BIT 1

// field positions in the receive control register
`define UBRG_RX_PORT_EN_BIT 7

// prescaler terminal counts: divide by 64, 16 and 4
`define UBRG_PRESC_ASYNC_LOW 6'h3F
`define UBRG_PRESC_ASYNC_HIGH 6'h0F
`define UBRG_PRESC_SYNC 6'h03

// axi responses
`define UBRG_RESP_OKAY 2'h0
`define UBRG_RESP_SLVERR 2'h2

`endif

// ### pkg/ubrg_pkg.sv
package ubrg_pkg;

  // divide ratio selected by the mode bits
  typedef enum logic [1:0] {
    UBRG_RATE_ASYNC_LOW,
    UBRG_RATE_ASYNC_HIGH,
    UBRG_RATE_SYNC
  } ubrg_rate_t;

  typedef logic [7:0] ubrg_byte_t;

endpackage

// ### logic/ubrg_majority.sv
// three-sample majority detector for the receive data pin
module ubrg_majority (
  input wire logic clk_i,      // oscillator clock
  input wire logic rst_n_i,    // synchronous reset, active low
  input wire logic sample_i,   // one-cycle sample strobe
  input wire logic pin_i,      // receive data pin level
  output logic level_o         // voted level
);
  import ubrg_pkg::*;

  logic [2:0] smp_r;

  // shift window of three samples; idle line is high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      smp_r <= 3'h7;
    end else if (sample_i) begin
      smp_r <= {smp_r[1:0], pin_i};
    end
  end

  // two of three wins, so one glitchy sample cannot flip the level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b1;
    end else begin
      level_o <= (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) |
                 (smp_r[0] & smp_r[2]);
    end
  end

endmodule

// ### logic/ubrg_top.sv
// Decided for this implementation: the address map and register access over AXI4-Lite.
`include "ubrg_regs.svh"

// Notes on behaviour
// - one 8-bit generator serves both modes
// - free-running timer, period from divisor register
// - every divisor value 0 to 255 accepted
// - high-speed bit steers asynchronous divide ratio
// - synchronous mode ignores the high-speed bit
// - async low speed: divide by 64(X+1)
// - async high speed: divide by 16(X+1)
// - synchronous: divide by 4(X+1)
// - synchronous rates only as master with internal clock
// - divisor write clears the timer at once
// - receive pin voted by three-sample majority
// - same reset values on every reset
module ubrg_top #(
  parameter int DIV_W = 8            // divisor and timer width
) (
  input wire logic clk_i,            // oscillator clock, 20 MHz
  input wire logic rst_n_i,          // synchronous reset, active low
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,  // write byte address
  input wire logic s_axi_awvalid,    // write address valid
  output logic s_axi_awready,        // write address ready
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,  // write data
  input wire logic [3:0] s_axi_wstrb,   // byte enables
  input wire logic s_axi_wvalid,     // write data valid
  output logic s_axi_wready,         // write data ready
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,    // write response
  output logic s_axi_bvalid,         // write response valid
  input wire logic s_axi_bready,     // write response ready
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,  // read byte address
  input wire logic s_axi_arvalid,    // read address valid
  output logic s_axi_arready,        // read address ready
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,   // read data
  output logic [1:0] s_axi_rresp,    // read response
  output logic s_axi_rvalid,         // read data valid
  input wire logic s_axi_rready,     // read data ready
  // usart side
  input wire logic receive_data_pin_i,  // receive data pin
  output logic rate_tick_o,          // one pulse per bit period
  output logic sample_tick_o,        // one pulse per timer step
  output logic rx_level_o,           // majority-voted receive level
  output logic gen_active_o,         // generator sets the rate
  output logic sync_mode_o,          // synchronous mode selected
  output ubrg_pkg::ubrg_byte_t tx_control_o,  // transmit control
  output ubrg_pkg::ubrg_byte_t rx_control_o   // receive control
);
  import ubrg_pkg::*;

  // the register holds 8 bits; the timer cannot be wider than that
  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
    $error("ubrg_top: DIV_W must lie between 1 and 8");
  end

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // divide mode from the transmit control bits
  function automatic ubrg_rate_t rate_of(input ubrg_byte_t ctl);
    ubrg_rate_t m;
    if (ctl[`UBRG_TX_SYNC_BIT]) begin
      m = UBRG_RATE_SYNC;
    end else if (ctl[`UBRG_TX_HIGH_SPEED_BIT]) begin
      m = UBRG_RATE_ASYNC_HIGH;
    end else begin
      m = UBRG_RATE_ASYNC_LOW;
    end
    return m;
  endfunction

  // last prescaler count for a mode
  function automatic logic [5:0] presc_last(input ubrg_rate_t m);
    logic [5:0] v;
    case (m)
      UBRG_RATE_ASYNC_LOW: begin
        v = `UBRG_PRESC_ASYNC_LOW;
      end
      UBRG_RATE_ASYNC_HIGH: begin
        v = `UBRG_PRESC_ASYNC_HIGH;
      end
      UBRG_RATE_SYNC: begin
        v = `UBRG_PRESC_SYNC;
      end
      default: begin
        v = `UBRG_PRESC_ASYNC_LOW;
      end
    endcase
    return v;
  endfunction

  // known register address check
  function automatic logic addr_known(input logic [3:0] a);
    return (a == `UBRG_ADDR_TXCTL) || (a == `UBRG_ADDR_RXCTL) ||
           (a == `UBRG_ADDR_DIV) || (a == `UBRG_ADDR_STAT);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ubrg_byte_t tx_ctl_r;
  ubrg_byte_t rx_ctl_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] tim_r;
  logic [5:0] presc_r;
  logic tick_r;
  logic step_r;
  logic rx_level;

  logic aw_full_r;
  logic [3:0] aw_addr_r;
  logic w_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  ubrg_rate_t rate_mode;
  logic [5:0] presc_end;
  logic gen_active;
  logic presc_wrap;
  logic tim_wrap;

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic wr_fire;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;
  logic wr_tx;
  logic wr_rx;
  logic wr_div;

  // each channel is held alone until its partner arrives
  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign have_aw = aw_full_r || aw_take;
  assign have_w = w_full_r || w_take;
  assign wr_fire = have_aw && have_w;
  assign wr_addr = aw_full_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_full_r ? w_data_r : s_axi_wdata;
  assign wr_lane0 = w_full_r ? w_strb_r[0] : s_axi_wstrb[0];

  // registers live in byte lane 0; other lanes are ignored
  assign wr_tx = wr_fire && wr_lane0 && (wr_addr == `UBRG_ADDR_TXCTL);
  assign wr_rx = wr_fire && wr_lane0 && (wr_addr == `UBRG_ADDR_RXCTL);
  assign wr_div = wr_fire && wr_lane0 && (wr_addr == `UBRG_ADDR_DIV);

  // address holding stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
  end

  // data holding stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // write response; unknown addresses answer slave error
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= `UBRG_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_known(wr_addr) ? `UBRG_RESP_OKAY
                                     : `UBRG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------

  // transmit control; read-only bits keep their reset value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_ctl_r <= `UBRG_TXCTL_RST;
    end else if (wr_tx) begin
      tx_ctl_r <= (wr_data[7:0] & `UBRG_TXCTL_WMASK) |
                  (tx_ctl_r & ~`UBRG_TXCTL_WMASK);
    end
  end

  // receive control; the error and ninth-bit flags stay clear here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_ctl_r <= `UBRG_RXCTL_RST;
    end else if (wr_rx) begin
      rx_ctl_r <= (wr_data[7:0] & `UBRG_RXCTL_WMASK) |
                  (rx_ctl_r & ~`UBRG_RXCTL_WMASK);
    end
  end

  // divisor: no value is refused
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r <= DIV_W'(`UBRG_DIV_RST);
    end else if (wr_div) begin
      div_r <= wr_data[DIV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------
  assign rate_mode = rate_of(tx_ctl_r);
  assign presc_end = presc_last(rate_mode);

  // a synchronous slave takes its clock from outside
  assign gen_active = !tx_ctl_r[`UBRG_TX_SYNC_BIT] ||
                      tx_ctl_r[`UBRG_TX_CLKSRC_BIT];

  assign presc_wrap = gen_active && (presc_r == presc_end);
  assign tim_wrap = presc_wrap && (tim_r == div_r);

  // prescaler; a mode change into a shorter ratio is caught by >=
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_r <= 6'h00;
    end else if (wr_div || !gen_active) begin
      presc_r <= 6'h00;
    end else if (presc_r >= presc_end) begin
      presc_r <= 6'h00;
    end else begin
      presc_r <= presc_r + 6'h01;
    end
  end

  // shared 8-bit timer counts 0..X, then reloads by itself
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tim_r <= '0;
    end else if (wr_div || !gen_active) begin
      tim_r <= '0;
    end else if (tim_wrap) begin
      tim_r <= '0;
    end else if (presc_wrap) begin
      tim_r <= tim_r + DIV_W'(1);
    end
  end

  // registered strobes, one cycle each
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_r <= 1'b0;
      step_r <= 1'b0;
    end else begin
      tick_r <= tim_wrap && !wr_div;
      step_r <= presc_wrap && !wr_div;
    end
  end

  // receive pin voter, sampled once per timer step
  ubrg_majority u_vote (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(step_r),
    .pin_i(receive_data_pin_i),
    .level_o(rx_level)
  );

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  logic ar_take;
  logic [31:0] rd_word;

  assign s_axi_arready = !rvalid_r;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // read multiplexer; status word shows live generator state
  always_comb begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      `UBRG_ADDR_TXCTL: begin
        rd_word[7:0] = tx_ctl_r;
      end
      `UBRG_ADDR_RXCTL: begin
        rd_word[7:0] = rx_ctl_r;
      end
      `UBRG_ADDR_DIV: begin
        rd_word[DIV_W-1:0] = div_r;
      end
      `UBRG_ADDR_STAT: begin
        rd_word[0] = rx_level;
        rd_word[1] = gen_active;
        rd_word[3:2] = rate_mode;
        rd_word[13:8] = presc_r;
        rd_word[16 +: DIV_W] = tim_r;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // read data held until the master takes it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `UBRG_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= addr_known(s_axi_araddr) ? `UBRG_RESP_OKAY
                                          : `UBRG_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ---------------------------------------------------------------
  // usart-facing outputs
  // ---------------------------------------------------------------
  assign rate_tick_o = tick_r;
  assign sample_tick_o = step_r;
  assign rx_level_o = rx_level;
  assign gen_active_o = gen_active;
  assign sync_mode_o = tx_ctl_r[`UBRG_TX_SYNC_BIT];
  assign tx_control_o = tx_ctl_r;
  assign rx_control_o = rx_ctl_r;

endmodule

// ### tb/ubrg_checker_sva.sv
// watches only the top-level ports of the rate generator
module ubrg_checker
  import ubrg_pkg::*;
#(
  parameter int DIV_W = 8  // divisor width, handed on by the bind
) (
  input wire logic clk_i,  // oscillator clock
  input wire logic rst_n_i,  // synchronous reset, active low
  input wire logic s_axi_awready,  // write address ready
  input wire logic s_axi_wready,  // write data ready
  input wire logic [1:0] s_axi_bresp,  // write response
  input wire logic s_axi_bvalid,  // write response valid
  input wire logic s_axi_bready,  // write response ready
  input wire logic s_axi_arready,  // read address ready
  input wire logic [31:0] s_axi_rdata,  // read data
  input wire logic [1:0] s_axi_rresp,  // read response
  input wire logic s_axi_rvalid,  // read data valid
  input wire logic s_axi_rready,  // read data ready
  input wire logic rate_tick_o,  // bit period pulse
  input wire logic sample_tick_o,  // timer step pulse
  input wire logic rx_level_o,  // voted receive level
  input wire logic gen_active_o,  // generator sets the rate
  input wire logic sync_mode_o,  // synchronous mode selected
  input ubrg_pkg::ubrg_byte_t tx_control_o,  // transmit control
  input ubrg_pkg::ubrg_byte_t rx_control_o  // receive control
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // bus answers must stand until the master takes them
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_write_blocked: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  a_reset_values: assert property ($rose(rst_n_i) |->
    tx_control_o == 8'h02 && rx_control_o == 8'h00 && rx_level_o &&
    gen_active_o && !sync_mode_o) else $error("bad reset value");
  // a bit period always ends on a timer step
  a_rate_on_step: assert property (rate_tick_o |-> sample_tick_o)
    else $error("rate tick off step");
  // no divide ratio is shorter than four clocks
  a_step_spacing: assert property (sample_tick_o |=>
    !sample_tick_o [*3]) else $error("steps too close");
  // slave clock: the generator stays quiet
  a_idle_quiet: assert property (!gen_active_o &&
    !$past(gen_active_o) |-> !sample_tick_o && !rate_tick_o)
    else $error("tick while idle");
  a_level_moves: assert property ($changed(rx_level_o) |->
    $past(sample_tick_o) || $past(sample_tick_o, 2))
    else $error("level moved off sample");
  a_mode_outputs: assert property (sync_mode_o == tx_control_o[4] &&
    gen_active_o == (!tx_control_o[4] || tx_control_o[7]))
    else $error("mode outputs wrong");

  c_rate_tick: cover property (rate_tick_o && sync_mode_o);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_idle: cover property (!gen_active_o);
endmodule

bind ubrg_top ubrg_checker #(.DIV_W(DIV_W)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rate_tick_o(rate_tick_o),
  .sample_tick_o(sample_tick_o), .rx_level_o(rx_level_o),
  .gen_active_o(gen_active_o), .sync_mode_o(sync_mode_o),
  .tx_control_o(tx_control_o), .rx_control_o(rx_control_o));

// ### tb/tb_usart_baud_rate_generator.sv
`include "ubrg_regs.svh"

module tb_usart_baud_rate_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, receive_data_pin_i;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rate_tick_o, sample_tick_o, rx_level_o;
  logic gen_active_o, sync_mode_o, bv_prev, armed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] tx_control_o, rx_control_o;
  logic [33:0] q_d[$], q_m[$];
  logic [1:0] q_b[$];
  int q_g[$];
  int mismatches = 0, checks_done = 0, cyc = 0, e_cyc = 0, per = 0;
  integer seed = 32'hec78e946;
  logic [7:0] txv [5] = '{8'h00, 8'h04, 8'h94, 8'h90, 8'h84};
  logic [7:0] xv [5] = '{8'h00, 8'hFF, 8'h02, 8'h00, 8'h01};
  int rv [5] = '{64, 16, 4, 4, 16};

  ubrg_top uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .receive_data_pin_i(receive_data_pin_i), .rate_tick_o(rate_tick_o),
    .sample_tick_o(sample_tick_o), .rx_level_o(rx_level_o),
    .gen_active_o(gen_active_o), .sync_mode_o(sync_mode_o),
    .tx_control_o(tx_control_o), .rx_control_o(rx_control_o));

  // 20 MHz oscillator
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    q_b.push_back(r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // read: expectation noted first, masked compare done by the monitor
  task automatic rd(input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic [1:0] r);
    q_d.push_back({r, d});
    q_m.push_back({2'b11, m});
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // hold the pin level across n timer steps
  task automatic pin_for(input logic v, input int n);
    @(posedge clk_i);
    receive_data_pin_i <= v;
    repeat (n) begin
      do @(posedge clk_i); while (!sample_tick_o);
    end
  endtask

  // monitor: pops the oldest note whenever a result shows up
  always @(posedge clk_i) begin
    cyc++;
    if (!rst_n_i) begin
      bv_prev = 1'b0;
      armed = 1'b0;
      per = 0;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        chk("rdata", q_d.pop_front(),
            {s_axi_rresp, s_axi_rdata} & q_m.pop_front());
      if (s_axi_bvalid && s_axi_bready)
        chk("bresp", {32'h0, q_b.pop_front()}, {32'h0, s_axi_bresp});
      // a write fired one edge before bvalid rose
      if (s_axi_bvalid && !bv_prev) begin
        e_cyc = cyc - 1;
        armed = 1'b1;
      end
      bv_prev = s_axi_bvalid;
      if (rate_tick_o) begin
        if (armed) begin
          armed = 1'b0;
          per = 0;
          if (q_g.size() > 0) begin
            per = q_g.pop_front();
            chk("first_tick", 34'(per + 1), 34'(cyc - e_cyc));
          end
        end else if (per > 0) begin
          chk("tick_period", 34'(per), 34'(cyc - e_cyc));
        end
        e_cyc = cyc;
      end
    end
  end

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    receive_data_pin_i = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wdata = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`UBRG_ADDR_TXCTL, 32'h02, 32'hFF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_RXCTL, 32'h00, 32'hFF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_DIV, 32'h00, 32'hFF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_STAT, 32'h3, 32'hF, `UBRG_RESP_OKAY);
    rd(4'h6, 32'h0, 32'hFFFFFFFF, `UBRG_RESP_SLVERR);
    // an unmapped write is answered with an error and changes nothing
    wr(4'h6, 8'hFF, 4'hF, `UBRG_RESP_SLVERR);
    wr(`UBRG_ADDR_TXCTL, 8'hFF, 4'hF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_TXCTL, 32'hF7, 32'hFF, `UBRG_RESP_OKAY);
    wr(`UBRG_ADDR_RXCTL, 8'hFF, 4'hF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_RXCTL, 32'hF8, 32'hFF, `UBRG_RESP_OKAY);
    // a cleared byte enable must leave the divisor alone
    wr(`UBRG_ADDR_DIV, 8'h5A, 4'h0, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_DIV, 32'h00, 32'hFF, `UBRG_RESP_OKAY);
    xv[0] = 8'($random(seed)) & 8'h3F;
    // every mode, with the divisor at 255 and 1 in async high speed and at 2 and 0 in synchronous
    for (int i = 0; i < 5; i++) begin
      wr(`UBRG_ADDR_TXCTL, txv[i], 4'hF, `UBRG_RESP_OKAY);
      wr(`UBRG_ADDR_DIV, xv[i], 4'hF, `UBRG_RESP_OKAY);
      q_g.push_back(rv[i] * (xv[i] + 1));
      repeat (2) begin
        do @(posedge clk_i); while (!rate_tick_o);
      end
      rd(`UBRG_ADDR_DIV, {24'h0, xv[i]}, 32'hFF, `UBRG_RESP_OKAY);
    end
    // external bit clock: generator held, status shows it
    wr(`UBRG_ADDR_TXCTL, 8'h10, 4'hF, `UBRG_RESP_OKAY);
    wr(`UBRG_ADDR_DIV, 8'h00, 4'hF, `UBRG_RESP_OKAY);
    repeat (40) @(posedge clk_i);
    rd(`UBRG_ADDR_STAT, 32'h8, 32'h00FF3F0E, `UBRG_RESP_OKAY);
    // fast steps for the voter; a lone sample must not flip it
    wr(`UBRG_ADDR_TXCTL, 8'h90, 4'hF, `UBRG_RESP_OKAY);
    wr(`UBRG_ADDR_DIV, 8'h00, 4'hF, `UBRG_RESP_OKAY);
    pin_for(1'b0, 3);
    repeat (2) @(posedge clk_i);
    rd(`UBRG_ADDR_STAT, 32'h0, 32'h1, `UBRG_RESP_OKAY);
    pin_for(1'b1, 1);
    pin_for(1'b0, 1);
    repeat (2) @(posedge clk_i);
    rd(`UBRG_ADDR_STAT, 32'h0, 32'h1, `UBRG_RESP_OKAY);
    pin_for(1'b1, 2);
    repeat (2) @(posedge clk_i);
    rd(`UBRG_ADDR_STAT, 32'h1, 32'h1, `UBRG_RESP_OKAY);
    // a second reset mid-run must bring back the same values
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`UBRG_ADDR_TXCTL, 32'h02, 32'hFF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_RXCTL, 32'h00, 32'hFF, `UBRG_RESP_OKAY);
    rd(`UBRG_ADDR_STAT, 32'h3, 32'hF, `UBRG_RESP_OKAY);
    repeat (4) @(posedge clk_i);
    final_report();
  end

  // watchdog: the sequence needs about 1 ms
  initial begin
    #3_000_000;
    mismatches++;
    final_report();
  end
endmodule
